// ---- core/fprc_regs.vh ----
// Constants for the fault precision and return control unit
`ifndef FPRC_REGS_VH
`define FPRC_REGS_VH
`define FPRC_TYPE_TRACE 4'h1
`define FPRC_TYPE_OPER 4'h2
`define FPRC_TYPE_ARITH 4'h3
`define FPRC_TYPE_CONSTR 4'h5
`define FPRC_TYPE_PROT 4'h7
`define FPRC_TYPE_TYPE 4'hA
`define FPRC_SUB_OVERFLOW 4'h1
`define FPRC_SUB_ZERO_DIV 4'h2
`define FPRC_SUB_RANGE 4'h1
`define FPRC_SUB_PRIV 4'h2
`define FPRC_AC_OVF_MASK_BIT 12
`define FPRC_AC_NIF_BIT 15
`define FPRC_AC_RESET 32'h00000000
`define FPRC_PCR_TRACE_EN_BIT 0
`define FPRC_PCR_TRACE_PEND_BIT 10
`define FPRC_PCR_MODE_BIT 1
`define FPRC_PCR_RESET 32'h00000002
`define FPRC_RET_LOCAL 1'b0
`define FPRC_RET_SUPER 1'b1
`define FPRC_OP_ARITH_OVF 3'h1
`define FPRC_OP_DIVIDE 3'h2
`define FPRC_OP_FAULT_IF 3'h3
`define FPRC_OP_PRIV 3'h4
`define FPRC_OP_SYNC 3'h5
`define FPRC_OP_NONE 3'h0
`endif

// ---- core/fprc_unit.v ----
// Fault precision, fault encoding and fault handler return control
`timescale 1ns/100ps
`include "fprc_regs.vh"
//
// How it works
// RULE_01: Supervisor return reloads arithmetic controls from record.
// RULE_02: Supervisor return reloads process controls from record.
// RULE_03: Return restores user mode if fault came from user.
// RULE_04: Return selects the stack active at fault.
// RULE_05: After return, higher interrupts first, then trace fault. (code pulses both in the same cycle)
// RULE_06: Handler changes to process controls are discarded.
// RULE_07: Interrupt during fault: select handler, interrupt, fault.
// RULE_08: Precise faults block issue and keep resumable pointer.
// RULE_09: Trace and protection faults are always precise.
// RULE_10: Imprecise faults still record correct fault address.
// RULE_11: No asynchronous faults are ever generated.
// RULE_12: With no-imprecise bit set, faults in order, precise.
// RULE_13: With bit clear, saved pointer may be unpredictable.
// RULE_14: Fault sync drains earlier instructions and their faults.
// RULE_15: Unmasked signed overflow raises type 3 subtype 1.
// RULE_16: Zero divisor raises subtype 2 before execution.
// RULE_17: Arithmetic return pointer is the next instruction.
// RULE_18: Matching fault-if raises type 5 subtype 1 after.
// RULE_19: Supervisor-only opcode in user mode raises subtype 2.
// RULE_20: Fault type and subtype go into the record.
// RULE_21: Local handler return restores arithmetic controls only.
// RULE_22: No-imprecise bit sampled on every issued instruction.
module fprc_unit #(
  parameter IP_W = 32
) (
  input wire core_clk_i, // Core clock
  input wire rst_n_i, // Asynchronous reset, active low
  input wire issue_valid_i, // Instruction offered for issue
  input wire [2:0] issue_op_i, // Fault-relevant class of the instruction
  input wire [IP_W-1:0] issue_ip_i, // Address of the instruction
  input wire [IP_W-1:0] issue_next_ip_i, // Address of the following instruction
  input wire ovf_detect_i, // Signed result overflowed its destination
  input wire divisor_zero_i, // Divide or remainder divisor is zero
  input wire cond_match_i, // Fault-if condition matches condition code
  input wire inflight_i, // Earlier instructions still unfinished
  input wire inflight_fault_i, // An unfinished earlier instruction will fault
  input wire ext_fault_valid_i, // Other unit fault with its own type
  input wire [3:0] ext_fault_type_i, // Its fault type
  input wire [3:0] ext_fault_sub_i, // Its subtype
  input wire [IP_W-1:0] ext_fault_ip_i, // Its faulting instruction address
  input wire ac_write_i, // Software write of arithmetic controls
  input wire [31:0] ac_wdata_i, // Data for that write
  input wire pcr_write_i, // Handler write of process controls
  input wire [31:0] pcr_wdata_i, // Data for that write
  input wire fault_ack_i, // Handler selection for current fault done
  input wire irq_pending_i, // Interrupt above current priority pending
  input wire irq_return_i, // Interrupt handler has returned
  input wire ret_valid_i, // Return from a fault handler
  input wire ret_kind_i, // Return kind: local or supervisor call
  input wire [31:0] rec_ac_i, // Saved arithmetic controls from record
  input wire [31:0] rec_pcr_i, // Saved process controls from record
  input wire rec_user_i, // Fault was taken in user mode
  output reg issue_ready_o, // Instruction may issue, registered from last cycle's next state and stall
  output reg fault_o, // Fault raised, one-cycle pulse
  output reg [3:0] fault_type_o, // Fault type field of the record
  output reg [3:0] fault_sub_o, // Fault subtype field of the record
  output reg [IP_W-1:0] fault_ip_o, // Faulting instruction address
  output reg [IP_W-1:0] ret_ip_o, // Return instruction pointer to save
  output reg precise_o, // Record is precise
  output reg write_result_o, // Low bits of result still written
  output reg [31:0] arith_controls_reg_o, // Arithmetic controls
  output reg [31:0] process_controls_reg_o, // Process controls
  output reg user_stack_o, // User stack selected
  output reg irq_take_o, // Service interrupt now, one-cycle pulse
  output reg trace_take_o, // Take pending trace fault, one-cycle pulse
  output reg handler_go_o // Start handler first instruction, pulse
);

  localparam ST_RUN = 2'h0;
  localparam ST_SEL = 2'h1;
  localparam ST_IRQ = 2'h2;
  localparam ST_RET = 2'h3;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [31:0] arith_controls_reg;
  reg [31:0] process_controls_reg;
  reg irq_seen;
  reg ret_trace;
  reg ret_irq;

  // Decode of supervisor mode from process controls
  function is_super;
    input [31:0] pcr;
    begin
      is_super = pcr[`FPRC_PCR_MODE_BIT];
    end
  endfunction

  wire no_imprecise_faults_bit = arith_controls_reg[`FPRC_AC_NIF_BIT]; // [RULE_22]
  wire user_mode = ~is_super(process_controls_reg);
  wire is_sync = issue_op_i == `FPRC_OP_SYNC;
  wire ovf_fault = (issue_op_i == `FPRC_OP_ARITH_OVF) & ovf_detect_i &
    ~arith_controls_reg[`FPRC_AC_OVF_MASK_BIT];
  wire div_fault = (issue_op_i == `FPRC_OP_DIVIDE) & divisor_zero_i;
  wire range_fault = (issue_op_i == `FPRC_OP_FAULT_IF) & cond_match_i;
  wire priv_fault = (issue_op_i == `FPRC_OP_PRIV) & user_mode;
  wire own_fault = ovf_fault | div_fault | range_fault | priv_fault;
  // Precise ordering stalls behind any unfinished faulting instruction
  wire need_order = no_imprecise_faults_bit | own_fault | is_sync; // [RULE_12] [RULE_08]
  wire stall = (need_order & inflight_fault_i) |
    (is_sync & inflight_i); // [RULE_14] [RULE_08]
  // An external fault in the same cycle holds issue back, so no own fault is lost
  wire go = issue_valid_i & (state == ST_RUN) & ~stall & ~ret_valid_i &
    ~ext_fault_valid_i;
  // Externally reported faults are always tied to an instruction address
  wire ext_go = ext_fault_valid_i & (state == ST_RUN) & ~ret_valid_i; // [RULE_11]
  wire ext_always_precise = (ext_fault_type_i == `FPRC_TYPE_TRACE) |
    (ext_fault_type_i == `FPRC_TYPE_PROT);

  // Handler sequencing state machine
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (ret_valid_i)
          next_state = ST_RET;
        else if (ext_go | (go & own_fault))
          next_state = ST_SEL;
      end
      ST_SEL: begin
        // Selection completes before any interrupt is serviced
        if (fault_ack_i)
          next_state = (irq_seen | irq_pending_i) ? ST_IRQ : ST_RUN; // [RULE_07]
      end
      ST_IRQ: begin
        if (irq_return_i)
          next_state = ST_RUN; // [RULE_07]
      end
      ST_RET: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // State, controls and fault record
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_RUN;
      arith_controls_reg <= `FPRC_AC_RESET;
      process_controls_reg <= `FPRC_PCR_RESET;
      irq_seen <= 1'b0;
      ret_trace <= 1'b0;
      ret_irq <= 1'b0;
      fault_o <= 1'b0;
      fault_type_o <= 4'h0;
      fault_sub_o <= 4'h0;
      fault_ip_o <= {IP_W{1'b0}};
      ret_ip_o <= {IP_W{1'b0}};
      precise_o <= 1'b0;
      write_result_o <= 1'b0;
      user_stack_o <= 1'b0;
      irq_take_o <= 1'b0;
      trace_take_o <= 1'b0;
      handler_go_o <= 1'b0;
    end else begin
      state <= next_state;
      fault_o <= 1'b0;
      write_result_o <= 1'b0;
      irq_take_o <= 1'b0;
      trace_take_o <= 1'b0;
      handler_go_o <= 1'b0;
      if (state == ST_SEL) begin
        if (irq_pending_i)
          irq_seen <= 1'b1;
        if (fault_ack_i) begin
          irq_seen <= 1'b0;
          // Interrupt goes ahead of the handler's first instruction
          irq_take_o <= irq_seen | irq_pending_i; // [RULE_07]
          handler_go_o <= ~(irq_seen | irq_pending_i);
        end
      end
      if ((state == ST_IRQ) & irq_return_i)
        handler_go_o <= 1'b1; // [RULE_07]
      // Software writes land before the next issue samples them
      if (ac_write_i)
        arith_controls_reg <= ac_wdata_i; // [RULE_22]
      if (pcr_write_i)
        process_controls_reg <= pcr_wdata_i;
      if (go)
        write_result_o <= (issue_op_i == `FPRC_OP_ARITH_OVF) & ovf_detect_i; // [RULE_15]
      if (ext_go) begin
        fault_o <= 1'b1;
        fault_type_o <= ext_fault_type_i; // [RULE_20]
        fault_sub_o <= ext_fault_sub_i; // [RULE_20]
        fault_ip_o <= ext_fault_ip_i; // [RULE_10]
        ret_ip_o <= issue_next_ip_i;
        precise_o <= no_imprecise_faults_bit | ext_always_precise; // [RULE_09] [RULE_13]
      end else if (go & own_fault) begin
        fault_o <= 1'b1;
        fault_ip_o <= issue_ip_i; // [RULE_10]
        ret_ip_o <= issue_next_ip_i; // [RULE_17]
        // Own faults are checked in order against the issue stream
        precise_o <= no_imprecise_faults_bit; // [RULE_12] [RULE_13]
        if (div_fault) begin
          fault_type_o <= `FPRC_TYPE_ARITH; // [RULE_16]
          fault_sub_o <= `FPRC_SUB_ZERO_DIV; // [RULE_16]
        end else if (ovf_fault) begin
          fault_type_o <= `FPRC_TYPE_ARITH; // [RULE_15]
          fault_sub_o <= `FPRC_SUB_OVERFLOW; // [RULE_15]
        end else if (priv_fault) begin
          fault_type_o <= `FPRC_TYPE_CONSTR; // [RULE_19]
          fault_sub_o <= `FPRC_SUB_PRIV; // [RULE_19]
        end else begin
          fault_type_o <= `FPRC_TYPE_CONSTR; // [RULE_18]
          fault_sub_o <= `FPRC_SUB_RANGE; // [RULE_18]
        end
      end
      if ((state == ST_RUN) & ret_valid_i) begin
        // Both return kinds restore the arithmetic controls
        arith_controls_reg <= rec_ac_i; // [RULE_01] [RULE_21]
        ret_irq <= irq_pending_i; // [RULE_05]
        if ((ret_kind_i == `FPRC_RET_SUPER) & is_super(process_controls_reg)) begin
          // Record copy overrides any handler change, mode follows fault
          process_controls_reg <= {rec_pcr_i[31:`FPRC_PCR_MODE_BIT+1], ~rec_user_i,
            rec_pcr_i[`FPRC_PCR_MODE_BIT-1:0]}; // [RULE_02] [RULE_06] [RULE_03]
          user_stack_o <= rec_user_i; // [RULE_04]
          ret_trace <= rec_pcr_i[`FPRC_PCR_TRACE_PEND_BIT] &
            rec_pcr_i[`FPRC_PCR_TRACE_EN_BIT]; // [RULE_05]
        end else begin
          ret_trace <= process_controls_reg[`FPRC_PCR_TRACE_PEND_BIT] &
            process_controls_reg[`FPRC_PCR_TRACE_EN_BIT]; // [RULE_21]
        end
      end
      if (state == ST_RET) begin
        // Interrupt and trace fault pulses are offered together in the same cycle
        irq_take_o <= ret_irq; // [RULE_05]
        trace_take_o <= ret_trace; // [RULE_05]
        ret_irq <= 1'b0;
        ret_trace <= 1'b0;
      end
      if (user_stack_o & (next_state == ST_SEL))
        user_stack_o <= 1'b0;
    end
  end

  // Mirror controls and issue permission onto registered outputs
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arith_controls_reg_o <= `FPRC_AC_RESET;
      process_controls_reg_o <= `FPRC_PCR_RESET;
      issue_ready_o <= 1'b0;
    end else begin
      arith_controls_reg_o <= arith_controls_reg;
      process_controls_reg_o <= process_controls_reg;
      // Registered view: one cycle stale, issue still gated internally
      issue_ready_o <= (next_state == ST_RUN) & ~stall; // [RULE_08]
    end
  end

endmodule

// ---- tb/fprc_props.sv ----
// Assertion checker for the fault precision and return control unit
`timescale 1ns/100ps
`include "fprc_regs.vh"
module fprc_props (
  input wire core_clk_i, // Core clock
  input wire rst_n_i, // Reset, active low
  input wire fault_ack_i, // Handler selection done
  input wire irq_pending_i, // Interrupt pending
  input wire irq_return_i, // Interrupt returned
  input wire ret_valid_i, // Handler return
  input wire ret_kind_i, // Return kind
  input wire [31:0] rec_ac_i, // Saved arithmetic controls
  input wire [31:0] rec_pcr_i, // Saved process controls
  input wire rec_user_i, // Fault taken in user mode
  input wire fault_o, // Fault pulse
  input wire [3:0] fault_type_o, // Fault type
  input wire [3:0] fault_sub_o, // Fault subtype
  input wire [31:0] arith_controls_reg_o, // Arithmetic controls
  input wire [31:0] process_controls_reg_o, // Process controls
  input wire user_stack_o, // User stack selected
  input wire irq_take_o, // Interrupt service pulse
  input wire trace_take_o, // Trace fault pulse
  input wire handler_go_o // Handler start pulse
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Process controls come from the record only when the handler runs supervised
  wire sup_ret = ret_valid_i && ret_kind_i && process_controls_reg_o[`FPRC_PCR_MODE_BIT];
  arith_sub_a: assert property (fault_o && fault_type_o == `FPRC_TYPE_ARITH |->
    fault_sub_o inside {`FPRC_SUB_OVERFLOW, `FPRC_SUB_ZERO_DIV}) else $error("bad arith sub");
  constr_sub_a: assert property (fault_o && fault_type_o == `FPRC_TYPE_CONSTR |->
    fault_sub_o inside {`FPRC_SUB_RANGE, `FPRC_SUB_PRIV}) else $error("bad constr sub");
  handler_go_a: assert property (fault_ack_i && !irq_pending_i |-> ##1 handler_go_o)
    else $error("handler start late");
  irq_first_a: assert property (fault_ack_i && irq_pending_i |-> ##1 irq_take_o && !handler_go_o)
    else $error("interrupt not first");
  irq_hold_a: assert property (irq_take_o |=> !handler_go_o) else $error("handler too early");
  ac_restore_a: assert property (ret_valid_i |-> ##[1:3] arith_controls_reg_o == rec_ac_i)
    else $error("arith controls not restored");
  mode_user_a: assert property (sup_ret && rec_user_i |->
    ##[1:3] !process_controls_reg_o[`FPRC_PCR_MODE_BIT]) else $error("user mode not restored");
  stack_user_a: assert property (sup_ret && rec_user_i |-> ##[1:3] user_stack_o)
    else $error("user stack not selected");
  pend_restore_a: assert property (sup_ret |-> ##[1:3]
    process_controls_reg_o[`FPRC_PCR_TRACE_PEND_BIT] == rec_pcr_i[`FPRC_PCR_TRACE_PEND_BIT])
    else $error("trace pending not restored");
  trace_after_a: assert property (sup_ret && !irq_pending_i && rec_pcr_i[`FPRC_PCR_TRACE_EN_BIT]
    && rec_pcr_i[`FPRC_PCR_TRACE_PEND_BIT] |-> ##[1:4] trace_take_o)
    else $error("trace fault missing");
endmodule
bind fprc_unit fprc_props i_fprc_props (.*);

// ---- tb/fprc_unit_test.sv ----
// Self-checking bench for the fault precision and return control unit
`timescale 1ns/100ps
`include "fprc_regs.vh"
module fprc_unit_test;
  reg core_clk_i = 1'b0, rst_n_i = 1'b0, issue_valid_i = 1'b0, ovf_detect_i = 1'b0;
  reg divisor_zero_i = 1'b0, cond_match_i = 1'b0, inflight_i = 1'b0, inflight_fault_i = 1'b0;
  reg ext_fault_valid_i = 1'b0, ac_write_i = 1'b0, pcr_write_i = 1'b0, fault_ack_i = 1'b0;
  reg irq_pending_i = 1'b0, irq_return_i = 1'b0, ret_valid_i = 1'b0, ret_kind_i = 1'b0;
  reg rec_user_i = 1'b0;
  reg [2:0] issue_op_i = 3'h0;
  reg [3:0] ext_fault_type_i = 4'h0, ext_fault_sub_i = 4'h0;
  reg [31:0] issue_ip_i = 32'h100, issue_next_ip_i = 32'h104, ext_fault_ip_i = 32'h0;
  reg [31:0] ac_wdata_i = 32'h0, pcr_wdata_i = 32'h0, rec_ac_i = 32'h0, rec_pcr_i = 32'h0;
  wire issue_ready_o, fault_o, precise_o, write_result_o, user_stack_o;
  wire irq_take_o, trace_take_o, handler_go_o;
  wire [3:0] fault_type_o, fault_sub_o;
  wire [31:0] fault_ip_o, ret_ip_o, arith_controls_reg_o, process_controls_reg_o;
  integer mismatches = 0, checked = 0, cycles = 0;
  integer nf = 0, ni = 0, ng = 0, nt = 0, nw = 0, ef = 0, ei = 0, eg = 0, et = 0, ew = 0;
  fprc_unit i_fprc_unit (.*);
  always #5 core_clk_i = ~core_clk_i;
  // Running pulse totals, so a missed or doubled pulse shows in any later compare
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    nf <= nf + (fault_o === 1'b1);
    ni <= ni + (irq_take_o === 1'b1);
    ng <= ng + (handler_go_o === 1'b1);
    nt <= nt + (trace_take_o === 1'b1);
    nw <= nw + (write_result_o === 1'b1);
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end
  task complete_run;
    begin
      $display("Comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input [8*14-1:0] what);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task setreg(input [31:0] ac, input [31:0] pc);
    begin
      ac_wdata_i <= ac;
      pcr_wdata_i <= pc;
      ac_write_i <= 1'b1;
      pcr_write_i <= 1'b1;
      tick(1);
      ac_write_i <= 1'b0;
      pcr_write_i <= 1'b0;
      tick(2);
    end
  endtask
  // Interrupt, if pending, must be served between selection and the handler
  task ack(input irq);
    begin
      irq_pending_i <= irq;
      fault_ack_i <= 1'b1;
      tick(1);
      fault_ack_i <= 1'b0;
      irq_pending_i <= 1'b0;
      tick(2);
      ei = ei + irq;
      eg = eg + !irq;
      chk(ni, ei, "irq take");
      chk(ng, eg, "early handler");
      irq_return_i <= irq;
      tick(1);
      irq_return_i <= 1'b0;
      tick(2);
      eg = eg + irq;
      chk(ng, eg, "handler go");
    end
  endtask
  task trial(input [2:0] op, input [2:0] q, input f, input [7:0] code, input irq);
    begin
      {ovf_detect_i, divisor_zero_i, cond_match_i} <= q;
      issue_op_i <= op;
      issue_ip_i <= issue_ip_i + 32'h8;
      issue_next_ip_i <= issue_ip_i + 32'hC;
      issue_valid_i <= 1'b1;
      tick(1);
      issue_valid_i <= 1'b0;
      tick(3);
      ef = ef + f;
      chk(nf, ef, "fault count");
      if (f) begin
        chk({fault_type_o, fault_sub_o}, code, "fault code");
        chk(fault_ip_o, issue_ip_i, "fault ip");
        if (code[7:4] == `FPRC_TYPE_ARITH)
          chk(ret_ip_o, issue_next_ip_i, "return ip");
        ack(irq);
      end
    end
  endtask
  task arith_faults;
    begin
      trial(`FPRC_OP_ARITH_OVF, 3'h4, 1'b1, 8'h31, 1'b0);
      chk(precise_o, 1'b0, "imprecise");
      setreg(32'h1000, `FPRC_PCR_RESET);
      trial(`FPRC_OP_ARITH_OVF, 3'h4, 1'b0, 8'h00, 1'b0);
      ew = ew + 2;
      chk(nw, ew, "result write");
      trial(`FPRC_OP_DIVIDE, 3'h2, 1'b1, 8'h32, 1'b1);
      trial(`FPRC_OP_DIVIDE, 3'h0, 1'b0, 8'h00, 1'b0);
    end
  endtask
  task constraint_faults;
    begin
      trial(`FPRC_OP_FAULT_IF, 3'h1, 1'b1, 8'h51, 1'b0);
      trial(`FPRC_OP_FAULT_IF, 3'h0, 1'b0, 8'h00, 1'b0);
      trial(`FPRC_OP_PRIV, 3'h0, 1'b0, 8'h00, 1'b0);
      setreg(32'h0, 32'h0);
      trial(`FPRC_OP_PRIV, 3'h0, 1'b1, 8'h52, 1'b0);
    end
  endtask
  // A held-back instruction must not fault until the earlier faulting work drains
  task precision;
    begin
      setreg(32'h8000, `FPRC_PCR_RESET);
      inflight_fault_i <= 1'b1;
      issue_op_i <= `FPRC_OP_DIVIDE;
      divisor_zero_i <= 1'b1;
      issue_valid_i <= 1'b1;
      tick(4);
      chk(nf, ef, "blocked fault");
      inflight_fault_i <= 1'b0;
      tick(1);
      issue_valid_i <= 1'b0;
      tick(3);
      ef = ef + 1;
      chk(nf, ef, "released fault");
      chk(precise_o, 1'b1, "precise nif");
      ack(1'b0);
      inflight_i <= 1'b1;
      issue_op_i <= `FPRC_OP_SYNC;
      issue_valid_i <= 1'b1;
      tick(3);
      chk(issue_ready_o, 1'b0, "sync stall");
      inflight_i <= 1'b0;
      tick(1);
      issue_valid_i <= 1'b0;
      tick(1);
      chk(issue_ready_o, 1'b1, "sync release");
      setreg(32'h0, `FPRC_PCR_RESET);
      ext_fault_type_i <= `FPRC_TYPE_TRACE;
      ext_fault_sub_i <= 4'h2;
      ext_fault_ip_i <= 32'h200;
      ext_fault_valid_i <= 1'b1;
      tick(1);
      ext_fault_valid_i <= 1'b0;
      tick(3);
      ef = ef + 1;
      chk(nf, ef, "ext fault");
      chk(fault_ip_o, 32'h200, "ext fault ip");
      chk(fault_type_o, `FPRC_TYPE_TRACE, "trace type");
      chk(precise_o, 1'b1, "precise trace");
      ack(1'b0);
    end
  endtask
  task handler_ret(input kind, input user, input [31:0] ac, input [31:0] pc);
    begin
      ret_kind_i <= kind;
      rec_user_i <= user;
      rec_ac_i <= ac;
      rec_pcr_i <= pc;
      ret_valid_i <= 1'b1;
      tick(1);
      ret_valid_i <= 1'b0;
      tick(3);
    end
  endtask
  task returns;
    begin
      setreg(32'h0, 32'h402);
      handler_ret(`FPRC_RET_LOCAL, 1'b1, 32'h1000, 32'h1);
      chk(arith_controls_reg_o, 32'h1000, "local ac");
      chk(process_controls_reg_o, 32'h402, "local pc");
      handler_ret(`FPRC_RET_SUPER, 1'b1, 32'h8000, 32'h401);
      chk(arith_controls_reg_o, 32'h8000, "super ac");
      chk(process_controls_reg_o, 32'h401, "super pc");
      chk(user_stack_o, 1'b1, "user stack");
      et = et + 1;
      chk(nt, et, "trace take");
      setreg(32'h0, `FPRC_PCR_RESET);
      irq_pending_i <= 1'b1;
      handler_ret(`FPRC_RET_SUPER, 1'b0, 32'h0, `FPRC_PCR_RESET);
      irq_pending_i <= 1'b0;
      ei = ei + 1;
      chk(ni, ei, "return irq");
      chk(user_stack_o, 1'b0, "super stack");
    end
  endtask
  initial begin
    tick(20);
    rst_n_i <= 1'b1;
    tick(1);
    chk(process_controls_reg_o, `FPRC_PCR_RESET, "pc reset");
    arith_faults;
    constraint_faults;
    precision;
    returns;
    complete_run;
  end
endmodule
